// ===== hdl/gpmp_port.v
// Eight-pin general-purpose I/O port with address-masked data access, Wishbone slave
//
// Contract
// - Reset: all pins software inputs; debug-port pins reset with alternate select one.
// - Power-on and external reset both restore defaults, debug pins included.
// - Data register spans 256 words; address bits 9:2 form bit mask.
// - Data write changes only bits whose address mask bit is one.
// - Data read returns masked bits; unmasked bits read zero.
// - One direction bit per pin selects input or output.
// - Direction one means output, zero means input.
// - Data read gives written value for outputs, pin level for inputs.
// - One interrupt output, high when any enabled pin condition active.
// - Edge interrupts stay latched until software clears them.
// - Sense bit zero selects edge, one selects level detection.
// - Both-edges bit one detects either edge, ignoring polarity.
// - Polarity zero means low or falling, one means high or rising.
// - Mask bit zero blocks pin condition, one passes it.
// - Raw status shows every pin meeting its condition, mask ignored.
// - Masked status shows raw conditions whose mask bit is one.
// - Writing one to clear register clears latched interrupt; zero no effect.
// - Changing sense settings may raise spurious interrupts; mask first.
// - Unmasked converter-trigger pin condition also drives converter trigger.
// - Alternate select one hands output, enable and input to peripheral.
// - Read-only identification registers hold fixed values from reset.
`include "gpmp_defines.vh"

module gpmp_port #(
  parameter [7:0]  ALT_RESET  = 8'h00,
  parameter [31:0] ID_WORD_0  = 32'h0000_0000, // Arbitrary identification value
  parameter [31:0] ID_WORD_1  = 32'h0000_0000, // Arbitrary identification value
  parameter [31:0] ID_WORD_2  = 32'h0000_0000, // Arbitrary identification value
  parameter [31:0] ID_WORD_3  = 32'h0000_0000, // Arbitrary identification value
  parameter        TRIG_EN    = 1
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  pin_i,
  output reg  [7:0]  pin_o,
  output reg  [7:0]  pin_oe_o,
  input  wire [7:0]  alt_out_i,
  input  wire [7:0]  alt_oe_i,
  output reg  [7:0]  alt_in_o,
  output reg  [7:0]  digital_input_enable_o,
  output reg  [7:0]  open_drain_select_o,
  output reg  [7:0]  pull_up_select_o,
  output reg  [7:0]  pull_down_select_o,
  output reg  [7:0]  drive_low_select_o,
  output reg  [7:0]  drive_mid_select_o,
  output reg  [7:0]  drive_high_select_o,
  output reg  [7:0]  slew_control_select_o,
  output reg         irq_o,
  output reg         converter_trigger_o
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [7:0] pin_data_reg;
  reg  [7:0] pin_direction_reg;
  reg  [7:0] alt_function_select_reg;
  reg  [7:0] irq_sense_select_reg;
  reg  [7:0] irq_both_edges_reg;
  reg  [7:0] irq_event_polarity_reg;
  reg  [7:0] irq_mask_enable_reg;
  reg  [7:0] edge_latch_reg;
  reg  [7:0] sync1_reg;
  reg  [7:0] sync2_reg;
  reg  [7:0] prev_reg;
  reg  [7:0] drv2_reg;
  reg  [7:0] drv4_reg;
  reg  [7:0] drv8_reg;
  reg  [7:0] odr_reg;
  reg  [7:0] pur_reg;
  reg  [7:0] pdr_reg;
  reg  [7:0] slr_reg;
  reg  [7:0] den_reg;

  wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr_req  = req & wb_we_i & wb_sel_i[0];
  wire [7:0] addr_mask = wb_adr_i[`GPMP_MASK_LSB+7:`GPMP_MASK_LSB];

  // Word-aligned match; sub-word address bits ignored
  function hit;
    input [11:0] adr;
    input [11:0] ofs;
    begin
      hit = (adr[11:2] == ofs[11:2]);
    end
  endfunction

  wire data_hit = (wb_adr_i < `GPMP_DATA_LIMIT);

  // ------------------------------------------------------------
  // Input synchroniser and event detection
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= `GPMP_RST_ZERO;
      sync2_reg <= `GPMP_RST_ZERO;
      prev_reg  <= `GPMP_RST_ZERO;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire [7:0] rise = sync2_reg & ~prev_reg;
  wire [7:0] fall = ~sync2_reg & prev_reg;
  wire [7:0] edge_hit;
  wire [7:0] level_hit;
  wire [7:0] raw_status;
  wire [7:0] masked_status;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_det
      // Both-edges overrides polarity
      assign edge_hit[g]  = irq_both_edges_reg[g] ? (rise[g] | fall[g]) :
                            (irq_event_polarity_reg[g] ? rise[g] : fall[g]);
      assign level_hit[g] = irq_event_polarity_reg[g] ? sync2_reg[g] : ~sync2_reg[g];
      // Level status is live, never latched; source must hold it
      assign raw_status[g] = irq_sense_select_reg[g] ? level_hit[g]
                                                     : edge_latch_reg[g];
    end
  endgenerate

  assign masked_status = raw_status & irq_mask_enable_reg;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  wire [7:0] clr_bits = (wr_req && hit(wb_adr_i, `GPMP_OFS_CLR)) ? wb_dat_i[7:0] : 8'h00;

  always @(posedge clk_i) begin
    // Any reset source lands here, debug pins included
    if (rst_i) begin
      pin_data_reg   <= `GPMP_RST_ZERO;
      edge_latch_reg <= `GPMP_RST_ZERO;
    end else begin
      // New edge wins over a clear in the same cycle
      edge_latch_reg <= (edge_latch_reg & ~clr_bits) | edge_hit;
      if (wr_req && data_hit) begin
        pin_data_reg <= (pin_data_reg & ~addr_mask) | (wb_dat_i[7:0] & addr_mask);
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_DIR)) begin
      pin_direction_reg <= wb_dat_i[7:0];
    end
  end

  // Debug pins come out of any reset owned by their peripheral
  always @(posedge clk_i) begin
    if (rst_i) begin
      alt_function_select_reg <= ALT_RESET;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_ALT)) begin
      alt_function_select_reg <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt configuration registers
  // ------------------------------------------------------------
  // No guard against live changes; software masks first
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_sense_select_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_SENSE)) begin
      irq_sense_select_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_both_edges_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_BOTH)) begin
      irq_both_edges_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_event_polarity_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_POL)) begin
      irq_event_polarity_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_enable_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_MASK)) begin
      irq_mask_enable_reg <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // Pad configuration registers
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      drv2_reg <= `GPMP_RST_DRV2;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_DRV2)) begin
      drv2_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      drv4_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_DRV4)) begin
      drv4_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      drv8_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_DRV8)) begin
      drv8_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      odr_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_ODR)) begin
      odr_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pur_reg <= `GPMP_RST_PUR;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_PUR)) begin
      pur_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pdr_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_PDR)) begin
      pdr_reg <= wb_dat_i[7:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      slr_reg <= `GPMP_RST_ZERO;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_SLR)) begin
      slr_reg <= wb_dat_i[7:0];
    end
  end

  // Digital input enable resets set, so pins work as digital by default
  always @(posedge clk_i) begin
    if (rst_i) begin
      den_reg <= `GPMP_RST_DEN;
    end else if (wr_req && hit(wb_adr_i, `GPMP_OFS_DEN)) begin
      den_reg <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  // Outputs read back the latch, inputs the synchronised level
  wire [7:0] data_view = (pin_direction_reg & pin_data_reg) |
                         (~pin_direction_reg & sync2_reg);
  reg  [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    if (data_hit) begin
      rd_next = {24'h00_0000, data_view & addr_mask};
    end else if (hit(wb_adr_i, `GPMP_OFS_DIR)) begin
      rd_next = {24'h00_0000, pin_direction_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_SENSE)) begin
      rd_next = {24'h00_0000, irq_sense_select_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_BOTH)) begin
      rd_next = {24'h00_0000, irq_both_edges_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_POL)) begin
      rd_next = {24'h00_0000, irq_event_polarity_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_MASK)) begin
      rd_next = {24'h00_0000, irq_mask_enable_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_RAW)) begin
      rd_next = {24'h00_0000, raw_status};
    end else if (hit(wb_adr_i, `GPMP_OFS_MIS)) begin
      rd_next = {24'h00_0000, masked_status};
    end else if (hit(wb_adr_i, `GPMP_OFS_ALT)) begin
      rd_next = {24'h00_0000, alt_function_select_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_DRV2)) begin
      rd_next = {24'h00_0000, drv2_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_DRV4)) begin
      rd_next = {24'h00_0000, drv4_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_DRV8)) begin
      rd_next = {24'h00_0000, drv8_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_ODR)) begin
      rd_next = {24'h00_0000, odr_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_PUR)) begin
      rd_next = {24'h00_0000, pur_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_PDR)) begin
      rd_next = {24'h00_0000, pdr_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_SLR)) begin
      rd_next = {24'h00_0000, slr_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_DEN)) begin
      rd_next = {24'h00_0000, den_reg};
    end else if (hit(wb_adr_i, `GPMP_OFS_ID_BASE + 12'h010)) begin
      rd_next = ID_WORD_0;
    end else if (hit(wb_adr_i, `GPMP_OFS_ID_BASE + 12'h014)) begin
      rd_next = ID_WORD_1;
    end else if (hit(wb_adr_i, `GPMP_OFS_ID_BASE + 12'h018)) begin
      rd_next = ID_WORD_2;
    end else if (hit(wb_adr_i, `GPMP_OFS_ID_BASE + 12'h01C)) begin
      rd_next = ID_WORD_3;
    end
  end

  // ------------------------------------------------------------
  // Bus answer and pin outputs
  // ------------------------------------------------------------
  // One-cycle answer; unmapped addresses still ack, read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_next : 32'h0000_0000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_o                  <= `GPMP_RST_ZERO;
      pin_oe_o               <= `GPMP_RST_ZERO;
      alt_in_o               <= `GPMP_RST_ZERO;
      irq_o                  <= 1'b0;
      converter_trigger_o    <= 1'b0;
      digital_input_enable_o <= `GPMP_RST_DEN;
      open_drain_select_o    <= `GPMP_RST_ZERO;
      pull_up_select_o       <= `GPMP_RST_PUR;
      pull_down_select_o     <= `GPMP_RST_ZERO;
      drive_low_select_o     <= `GPMP_RST_DRV2;
      drive_mid_select_o     <= `GPMP_RST_ZERO;
      drive_high_select_o    <= `GPMP_RST_ZERO;
      slew_control_select_o  <= `GPMP_RST_ZERO;
    end else begin
      pin_o    <= (alt_function_select_reg & alt_out_i) |
                  (~alt_function_select_reg & pin_data_reg);
      pin_oe_o <= (alt_function_select_reg & alt_oe_i) |
                  (~alt_function_select_reg & pin_direction_reg);
      alt_in_o <= sync2_reg & alt_function_select_reg;
      irq_o    <= |masked_status;
      // Only the designated trigger pin; other ports pass TRIG_EN=0
      converter_trigger_o <= (TRIG_EN != 0) & masked_status[`GPMP_ADC_PIN];
      digital_input_enable_o <= den_reg;
      open_drain_select_o    <= odr_reg;
      pull_up_select_o       <= pur_reg;
      pull_down_select_o     <= pdr_reg;
      drive_low_select_o     <= drv2_reg;
      drive_mid_select_o     <= drv4_reg;
      drive_high_select_o    <= drv8_reg;
      slew_control_select_o  <= slr_reg;
    end
  end

endmodule // gpmp_port

// ===== hdl/gpmp_defines.vh
// Register offsets, reset values and field positions of the masked-access GPIO port
`ifndef GPMP_DEFINES_VH
`define GPMP_DEFINES_VH
`define GPMP_OFS_DIR      12'h400
`define GPMP_OFS_SENSE    12'h404
`define GPMP_OFS_BOTH     12'h408
`define GPMP_OFS_POL      12'h40C
`define GPMP_OFS_MASK     12'h410
`define GPMP_OFS_RAW      12'h414
`define GPMP_OFS_MIS      12'h418
`define GPMP_OFS_CLR      12'h41C
`define GPMP_OFS_ALT      12'h420
`define GPMP_OFS_DRV2     12'h500
`define GPMP_OFS_DRV4     12'h504
`define GPMP_OFS_DRV8     12'h508
`define GPMP_OFS_ODR      12'h50C
`define GPMP_OFS_PUR      12'h510
`define GPMP_OFS_PDR      12'h514
`define GPMP_OFS_SLR      12'h518
`define GPMP_OFS_DEN      12'h51C
`define GPMP_OFS_ID_BASE  12'hFD0
`define GPMP_DATA_LIMIT   12'h400
`define GPMP_MASK_LSB     2
`define GPMP_RST_ZERO     8'h00
`define GPMP_RST_DRV2     8'hFF
`define GPMP_RST_PUR      8'hFF
`define GPMP_RST_DEN      8'hFF
`define GPMP_ADC_PIN      4
`endif

// ===== sim/gpmp_port_props.sv
// Concurrent checks on the masked-access port's bus and pad outputs
module gpmp_port_props (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic [7:0]  pin_oe_o,
  input logic [7:0]  alt_in_o,
  input logic        irq_o,
  input logic        converter_trigger_o,
  input logic [7:0]  digital_input_enable_o,
  input logic [7:0]  pull_up_select_o,
  input logic [7:0]  drive_low_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_trig_irq: assert property (converter_trigger_o |-> irq_o)
    else $error("trigger without port interrupt");
  // Reset checks must run while reset is high, so they drop the default disable
  a_reset_pads: assert property (disable iff (1'b0) rst_i |=> digital_input_enable_o == 8'hFF
    && pull_up_select_o == 8'hFF && drive_low_select_o == 8'hFF)
    else $error("pad selects not at reset value");
  a_reset_outs: assert property (disable iff (1'b0) rst_i |=> !irq_o && !converter_trigger_o
    && pin_oe_o[6:0] == 7'h0 && alt_in_o[6:0] == 7'h0)
    else $error("outputs not cleared by reset");
endmodule // gpmp_port_props

// ===== sim/gpmp_pin_model.sv
// Behavioural pads and alternate peripheral beside the port
module gpmp_pin_model (
  input  logic [7:0] pad_out_i,
  input  logic [7:0] pad_oe_i,
  input  logic [7:0] ext_i,
  output logic [7:0] pad_o,
  output logic [7:0] alt_out_o,
  output logic [7:0] alt_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside source holds each level until the bench changes it
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
  // Peripheral always drives high, so a hand-over shows at the pad
  assign alt_out_o = 8'hFF;
  assign alt_oe_o = 8'hFF;
endmodule // gpmp_pin_model

// ===== sim/tb_gpmp_port.sv
// Self-checking bench for the masked-access GPIO port
module tb_gpmp_port;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic we; logic [11:0] a; logic [7:0] d;} gpmp_op_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [3:0]  sel   = 4'hF;
  logic [31:0] wdat  = 32'h0;
  logic [7:0]  ext   = 8'h00;
  logic [31:0] rdat;
  logic        ack, irq, trig;
  logic [7:0]  pin_i, pin_o, pin_oe, alt_out, alt_oe, alt_in;
  logic [7:0]  den_o, odr_o, pur_o, pdr_o, dr2_o, dr4_o, dr8_o, slr_o;
  int          err_count = 0;
  int          cmp_count = 0;
  // Reads carry the expected value in d
  gpmp_op_t ops [0:18] = '{'{0,12'h400,8'h00}, '{0,12'h420,8'h80}, '{0,12'h51C,8'hFF},
    '{0,12'h500,8'hFF}, '{0,12'h510,8'hFF}, '{0,12'hFE0,8'hA5}, '{0,12'h600,8'h00},
    '{1,12'hFE0,8'h00}, '{0,12'hFE0,8'hA5}, '{1,12'h400,8'hFF}, '{1,12'h098,8'hEB},
    '{0,12'h3FC,8'h22}, '{1,12'h3FC,8'hFF}, '{0,12'h0C4,8'h31}, '{1,12'h004,8'h00},
    '{0,12'h3FC,8'hFE}, '{1,12'h200,8'h00}, '{0,12'h200,8'h00}, '{0,12'h3FC,8'h7E}};

  always #5 clk_i = ~clk_i;

  gpmp_port #(.ALT_RESET(8'h80), .ID_WORD_0(32'h0000_00A5), .TRIG_EN(1)) gpmp_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
    .alt_in_o(alt_in), .digital_input_enable_o(den_o), .open_drain_select_o(odr_o),
    .pull_up_select_o(pur_o), .pull_down_select_o(pdr_o), .drive_low_select_o(dr2_o),
    .drive_mid_select_o(dr4_o), .drive_high_select_o(dr8_o), .slew_control_select_o(slr_o),
    .irq_o(irq), .converter_trigger_o(trig));

  gpmp_pin_model gpmp_pin_model_inst (.pad_out_i(pin_o), .pad_oe_i(pin_oe), .ext_i(ext),
    .pad_o(pin_i), .alt_out_o(alt_out), .alt_oe_o(alt_oe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack is sampled before the slave's edge update lands
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("unexpected at %0t: no ack", $time);
    end else if (!w) chk(rdat, {24'h0, d});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_sync;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    // Bench clock runs from time zero, so the port clock is on before access
    rst_i <= 1'b0;
    foreach (ops[i]) acc(ops[i].we, ops[i].a, ops[i].d);
    $display("test table done");
    acc(1, 12'h400, 8'hF0);
    sel <= 4'hE;
    acc(1, 12'h400, 8'hFF);
    sel <= 4'hF;
    acc(0, 12'h400, 8'hF0);
    ext <= 8'h05;
    wait_sync;
    acc(0, 12'h1FC, 8'h75);
    chk({24'h0, pin_oe}, 32'hF0);
    chk({28'h0, pin_o[7:4]}, 32'hF);
    chk({24'h0, alt_in}, 32'h80);
    $display("test pins done");
    ext <= 8'h00;
    acc(1, 12'h40C, 8'h13);
    acc(1, 12'h404, 8'h18);
    acc(1, 12'h41C, 8'hFF);
    acc(1, 12'h410, 8'h11);
    acc(0, 12'h414, 8'h18);
    ext <= 8'h03;
    wait_sync;
    acc(0, 12'h414, 8'h1B);
    acc(0, 12'h418, 8'h11);
    chk({30'h0, irq, trig}, 32'h3);
    ext <= 8'h00;
    wait_sync;
    acc(1, 12'h41C, 8'h00);
    acc(0, 12'h414, 8'h1B);
    acc(1, 12'h41C, 8'h03);
    acc(0, 12'h414, 8'h18);
    acc(1, 12'h410, 8'h00);
    acc(1, 12'h408, 8'h01);
    acc(1, 12'h410, 8'h11);
    ext <= 8'h01;
    wait_sync;
    acc(1, 12'h41C, 8'h01);
    ext <= 8'h00;
    wait_sync;
    acc(0, 12'h414, 8'h19);
    acc(1, 12'h410, 8'h00);
    acc(0, 12'h418, 8'h00);
    chk({30'h0, irq, trig}, 32'h0);
    $display("test irq done");
    acc(1, 12'h50C, 8'h55);
    acc(1, 12'h514, 8'hAA);
    acc(1, 12'h504, 8'h0F);
    acc(1, 12'h508, 8'hF0);
    acc(1, 12'h518, 8'h3C);
    acc(1, 12'h500, 8'hC3);
    acc(1, 12'h510, 8'h5A);
    acc(1, 12'h51C, 8'hFE);
    @(posedge clk_i);
    chk({odr_o, pdr_o, dr4_o, dr8_o}, 32'h55AA0FF0);
    chk({slr_o, dr2_o, pur_o, den_o}, 32'h3CC35AFE);
    $display("test pads done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, 12'h400, 8'h00);
    acc(0, 12'h420, 8'h80);
    acc(0, 12'h410, 8'h00);
    chk({pur_o, dr2_o, den_o, odr_o}, 32'hFFFFFF00);
    $display("test reset done");
    final_report;
  end
endmodule // tb_gpmp_port

bind gpmp_port gpmp_port_props gpmp_port_props_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .pin_oe_o, .alt_in_o, .irq_o, .converter_trigger_o,
  .digital_input_enable_o, .pull_up_select_o, .drive_low_select_o);
